//--- rtl/tcs_timer.v
// timer clock select, shared prescaler, pin synchroniser and 16-bit counter
`timescale 1ns/1ps
`include "tcs_consts.vh"

// How it works
// - select 1 ticks every system clock
// - selects 2..5 use taps 8,64,256,1024
// - prescaler free-running, shared by attached timers
// - first prescaled count within 1..N+1 cycles
// - prescaler reset restarts period for all
// - count pin sampled once per clock
// - high-phase latch then rising-edge registers
// - select 7 rising, select 6 falling edges
// - pin edge to count 1.5..2.5 cycles
// - pin clock never goes through prescaler
// - counter steps by one or clears
// - top and bottom indications raised
// - upper-byte address reaches shared holding byte
// - low read latches upper, write loads 16
// - select 0 stops, cpu access stays
// - cpu write beats count and clear
// - four-bit mode split over controls b/a
// - overflow flag set per mode
// - top is fixed max or compare a
// - one holding byte shared by registers
module tcs_timer (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        external_count_pin,
  input  wire        psc_reset_ext,
  output wire        timer_tick,
  output reg  [15:0] count_value,
  output reg         top_hit,
  output reg         bottom_hit,
  output wire        overflow_flag
);

  // --------------------------------------------------------------------------
  // apb decode
  // --------------------------------------------------------------------------
  wire acc = psel & penable;
  wire wr  = acc & pwrite;
  wire rd  = acc & ~pwrite;

  function addr_is;
    input [7:0] a;
    input [7:0] ref_a;
    begin
      addr_is = (a == ref_a);
    end
  endfunction

  // one place knows the map, so a hole reads as zero and raises an error
  function addr_mapped;
    input [7:0] a;
    begin
      case (a)
        `TCS_ADDR_CTRL_A,
        `TCS_ADDR_CTRL_B,
        `TCS_ADDR_CNT_LO,
        `TCS_ADDR_CNT_HI,
        `TCS_ADDR_CMP_A_LO,
        `TCS_ADDR_CMP_A_HI,
        `TCS_ADDR_FLAGS,
        `TCS_ADDR_PSC_CTRL: addr_mapped = 1'b1;
        default:            addr_mapped = 1'b0;
      endcase
    end
  endfunction

  wire mapped = addr_mapped(paddr);

  // write strobes, decoded once
  wire cnt_hi_wr = wr & addr_is(paddr, `TCS_ADDR_CNT_HI);
  wire cmp_hi_wr = wr & addr_is(paddr, `TCS_ADDR_CMP_A_HI);
  wire cmp_lo_wr = wr & addr_is(paddr, `TCS_ADDR_CMP_A_LO);
  wire psc_wr    = wr & addr_is(paddr, `TCS_ADDR_PSC_CTRL);

  // read data is taken in the setup cycle, so the access phase shows a flop
  wire setup_rd  = psel & ~penable & ~pwrite;

  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;

  // --------------------------------------------------------------------------
  // control registers
  // --------------------------------------------------------------------------
  reg  [1:0] timer_control_a_r;
  reg  [4:0] timer_control_b_r;
  reg  [15:0] compare_value_a_r;
  reg  [7:0] hold_byte_r;
  reg        ovf_r;
  reg        top_flag_r;
  reg        bot_flag_r;
  reg  [31:0] prdata_r;
  reg  [7:0] cnt_hi_snap_r;

  wire [2:0] tick_source_select = timer_control_b_r[2:0];
  wire [3:0] waveform_mode_field = {timer_control_b_r[4:3], timer_control_a_r};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_control_a_r <= 2'h0;
      timer_control_b_r <= 5'h00;
    end else if (wr) begin
      if (addr_is(paddr, `TCS_ADDR_CTRL_A))
        timer_control_a_r <= pwdata[1:0];
      if (addr_is(paddr, `TCS_ADDR_CTRL_B))
        timer_control_b_r <= pwdata[4:0];
    end
  end

  // --------------------------------------------------------------------------
  // prescaler: free running, reset restarts all taps
  // --------------------------------------------------------------------------
  reg  [9:0] psc_r;
  wire       psc_reset = psc_reset_ext | (psc_wr & pwdata[`TCS_PSC_RESET_BIT]);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      psc_r <= 10'h000;
    else if (psc_reset)
      psc_r <= 10'h000;
    else
      psc_r <= psc_r + 10'h001;
  end

  // a tap pulses once in each period, when its low bits roll to all ones;
  // all taps read the one shared divider, so a reset moves them together
  wire [3:0] tap;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_tap
      localparam integer TAP_MSB = (gi == 0) ? 2 : (gi == 1) ? 5 : (gi == 2) ? 7 : 9;
      assign tap[gi] = &psc_r[TAP_MSB:0];
    end
  endgenerate

  wire tap8    = tap[0];
  wire tap64   = tap[1];
  wire tap256  = tap[2];
  wire tap1024 = tap[3];

  // --------------------------------------------------------------------------
  // count pin synchroniser and edge detector
  // --------------------------------------------------------------------------
  // the high-phase latch is modelled as a falling-edge capture; this holds
  // the pin value stable for the rising-edge stage and gives the half cycle
  reg pin_lat_r;
  reg pin_sync_r;
  reg pin_prev_r;

  always @(negedge pclk or negedge presetn) begin
    if (!presetn)
      pin_lat_r <= 1'b0;
    else
      pin_lat_r <= external_count_pin;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sync_r <= 1'b0;
      pin_prev_r <= 1'b0;
    end else begin
      pin_sync_r <= pin_lat_r;
      pin_prev_r <= pin_sync_r;
    end
  end

  wire pin_rise = pin_sync_r & ~pin_prev_r;
  wire pin_fall = ~pin_sync_r & pin_prev_r;

  // --------------------------------------------------------------------------
  // tick selection
  // --------------------------------------------------------------------------
  reg tick_sel;

  always @* begin
    case (tick_source_select)
      `TCS_CS_DIV1:     tick_sel = 1'b1;
      `TCS_CS_DIV8:     tick_sel = tap8;
      `TCS_CS_DIV64:    tick_sel = tap64;
      `TCS_CS_DIV256:   tick_sel = tap256;
      `TCS_CS_DIV1024:  tick_sel = tap1024;
      `TCS_CS_EXT_FALL: tick_sel = pin_fall;
      `TCS_CS_EXT_RISE: tick_sel = pin_rise;
      default:          tick_sel = 1'b0;
    endcase
  end

  assign timer_tick = tick_sel;

  // --------------------------------------------------------------------------
  // counter core
  // --------------------------------------------------------------------------
  reg         dir_down_r;
  reg  [15:0] top_val;
  reg  [15:0] count_nxt;
  reg         dir_nxt;
  reg         ovf_set;

  // only the compare-a modes take top from compare a; others run to max
  function mode_uses_cmp_a;
    input [3:0] m;
    begin
      case (m)
        `TCS_WGM_CTC_A: mode_uses_cmp_a = 1'b1;
        `TCS_WGM_PC_A:  mode_uses_cmp_a = 1'b1;
        default:        mode_uses_cmp_a = 1'b0;
      endcase
    end
  endfunction

  always @* begin
    if (mode_uses_cmp_a(waveform_mode_field))
      top_val = compare_value_a_r;
    else
      top_val = `TCS_MAX_COUNT;
  end

  wire at_top    = (count_value == top_val);
  wire at_bottom = (count_value == 16'h0000);
  wire dual_slope = (waveform_mode_field == `TCS_WGM_PC_A);

  always @* begin
    count_nxt = count_value;
    dir_nxt   = dir_down_r;
    ovf_set   = 1'b0;
    if (tick_sel) begin
      if (dual_slope) begin
        if (!dir_down_r && at_top) begin
          dir_nxt   = 1'b1;
          count_nxt = count_value - 16'h0001;
        end else if (dir_down_r && at_bottom) begin
          dir_nxt   = 1'b0;
          count_nxt = count_value + 16'h0001;
          ovf_set   = 1'b1;
        end else if (dir_down_r) begin
          count_nxt = count_value - 16'h0001;
        end else begin
          count_nxt = count_value + 16'h0001;
        end
      end else begin
        dir_nxt = 1'b0;
        if (at_top) begin
          count_nxt = 16'h0000;
          ovf_set   = (top_val == `TCS_MAX_COUNT);
        end else begin
          count_nxt = count_value + 16'h0001;
        end
      end
    end
  end

  wire cnt_lo_wr = wr & addr_is(paddr, `TCS_ADDR_CNT_LO);
  wire cnt_lo_rd = rd & addr_is(paddr, `TCS_ADDR_CNT_LO);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_value <= 16'h0000;
      dir_down_r  <= 1'b0;
      top_hit     <= 1'b0;
      bottom_hit  <= 1'b0;
    end else begin
      if (cnt_lo_wr)
        count_value <= {hold_byte_r, pwdata[7:0]};
      else
        count_value <= count_nxt;
      dir_down_r <= dir_nxt;
      top_hit    <= at_top;
      bottom_hit <= at_bottom;
    end
  end

  // --------------------------------------------------------------------------
  // holding byte shared by all 16-bit registers, compare a
  // --------------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      hold_byte_r <= 8'h00;
    else if (cnt_lo_rd)
      hold_byte_r <= cnt_hi_snap_r;
    else if (cnt_hi_wr | cmp_hi_wr)
      hold_byte_r <= pwdata[7:0];
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      compare_value_a_r <= `TCS_CMP_A_RESET;
    else if (cmp_lo_wr)
      compare_value_a_r <= {hold_byte_r, pwdata[7:0]};
  end

  // --------------------------------------------------------------------------
  // status flags: set wins over write-one-to-clear
  // --------------------------------------------------------------------------
  wire flg_wr = wr & addr_is(paddr, `TCS_ADDR_FLAGS);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_r      <= 1'b0;
      top_flag_r <= 1'b0;
      bot_flag_r <= 1'b0;
    end else begin
      ovf_r      <= ovf_set | (ovf_r & ~(flg_wr & pwdata[0]));
      top_flag_r <= (tick_sel & at_top) | (top_flag_r & ~(flg_wr & pwdata[1]));
      bot_flag_r <= (tick_sel & at_bottom) | (bot_flag_r & ~(flg_wr & pwdata[2]));
    end
  end

  assign overflow_flag = ovf_r;

  // --------------------------------------------------------------------------
  // read mux
  // --------------------------------------------------------------------------
  reg [7:0] rd_byte;

  always @* begin
    case (paddr)
      `TCS_ADDR_CTRL_A:   rd_byte = {6'h00, timer_control_a_r};
      `TCS_ADDR_CTRL_B:   rd_byte = {3'h0, timer_control_b_r};
      `TCS_ADDR_CNT_LO:   rd_byte = count_value[7:0];
      `TCS_ADDR_CNT_HI:   rd_byte = hold_byte_r;
      `TCS_ADDR_CMP_A_LO: rd_byte = compare_value_a_r[7:0];
      `TCS_ADDR_CMP_A_HI: rd_byte = compare_value_a_r[15:8];
      `TCS_ADDR_FLAGS:    rd_byte = {5'h00, bot_flag_r, top_flag_r, ovf_r};
      default:            rd_byte = 8'h00;
    endcase
  end

  // the upper count byte is snapshotted with the low byte, so the holding
  // byte pairs with the very low byte the cpu sees even while counting
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r      <= 32'h00000000;
      cnt_hi_snap_r <= 8'h00;
    end else if (setup_rd) begin
      prdata_r      <= {24'h000000, rd_byte};
      cnt_hi_snap_r <= count_value[15:8];
    end else begin
      prdata_r      <= 32'h00000000;
    end
  end

  assign prdata = prdata_r;

endmodule // tcs_timer

//--- rtl/tcs_consts.vh
// constants for the timer clock select and counter core
`ifndef TCS_CONSTS_VH
`define TCS_CONSTS_VH

// ----------------------------------------------------------------------------
// apb register byte addresses
// ----------------------------------------------------------------------------
`define TCS_ADDR_CTRL_A      8'h00
`define TCS_ADDR_CTRL_B      8'h04
`define TCS_ADDR_CNT_LO      8'h08
`define TCS_ADDR_CNT_HI      8'h0c
`define TCS_ADDR_CMP_A_LO    8'h10
`define TCS_ADDR_CMP_A_HI    8'h14
`define TCS_ADDR_FLAGS       8'h18
`define TCS_ADDR_PSC_CTRL    8'h1c

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define TCS_CTRL_A_WGM_LSB   0
`define TCS_CTRL_B_CS_LSB    0
`define TCS_CTRL_B_WGM_LSB   3
`define TCS_FLAGS_OVF_BIT    0
`define TCS_FLAGS_TOP_BIT    1
`define TCS_FLAGS_BOT_BIT    2
`define TCS_PSC_RESET_BIT    0

// ----------------------------------------------------------------------------
// tick source select codes
// ----------------------------------------------------------------------------
`define TCS_CS_STOP          3'h0
`define TCS_CS_DIV1          3'h1
`define TCS_CS_DIV8          3'h2
`define TCS_CS_DIV64         3'h3
`define TCS_CS_DIV256        3'h4
`define TCS_CS_DIV1024       3'h5
`define TCS_CS_EXT_FALL      3'h6
`define TCS_CS_EXT_RISE      3'h7

// ----------------------------------------------------------------------------
// waveform mode codes used by the counting sequence
// ----------------------------------------------------------------------------
`define TCS_WGM_NORMAL       4'h0
`define TCS_WGM_CTC_A        4'h4
`define TCS_WGM_PC_A         4'hb

// ----------------------------------------------------------------------------
// reset values and fixed figures
// ----------------------------------------------------------------------------
`define TCS_MAX_COUNT        16'hffff
`define TCS_CMP_A_RESET      16'h0000
`define TCS_PSC_WIDTH        10

`endif

//--- bench/tcs_timer_checker.sv
// checker for tick selection, prescaler taps and counter stepping
`timescale 1ns/1ps
module tcs_timer_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        external_count_pin,
  input wire logic        psc_reset_ext,
  input wire logic        timer_tick,
  input wire logic [15:0] count_value,
  input wire logic        bottom_hit
);
  logic [2:0] sel_r;
  wire        wr = psel && penable && pwrite;

  // shadow of the select field, updated on the same access edge as the design
  always @(posedge pclk or negedge presetn)
    if (!presetn) sel_r <= 3'h0;
    else if (wr && paddr == 8'h04) sel_r <= pwdata[2:0];

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence quiet7;
    !timer_tick [*7];
  endsequence

  // ---------------------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------------------
  AST_READY: assert property (psel |-> pready) else $error("no ready");
  AST_STOP:
    assert property (sel_r == 3'h0 |-> !timer_tick) else $error("tick while stopped");
  AST_DIV1:
    assert property (sel_r == 3'h1 |-> timer_tick) else $error("undivided tick missing");
  // a prescaler reset in mid-period legally stretches it
  AST_DIV8:
    assert property (disable iff (!presetn || psc_reset_ext || (wr && paddr == 8'h1c))
      sel_r == 3'h2 && timer_tick |-> ##1 quiet7 ##1 timer_tick) else $error("tap period");
  AST_PSC_RST:
    assert property ($fell(psc_reset_ext) && sel_r == 3'h2 |-> quiet7 ##1 timer_tick)
      else $error("prescaler restart");
  AST_EXT_RISE:
    assert property (sel_r == 3'h7 && $rose(external_count_pin) |-> ##[1:2] timer_tick)
      else $error("rising pin tick");
  AST_EXT_FALL:
    assert property (sel_r == 3'h6 && $fell(external_count_pin) |-> ##[1:2] timer_tick)
      else $error("falling pin tick");
  AST_STEP:
    assert property (timer_tick && !wr |=> count_value == $past(count_value) + 16'h1
      || count_value == $past(count_value) - 16'h1 || count_value == 16'h0)
      else $error("bad count step");
  AST_HOLD:
    assert property (!timer_tick && !wr |=> $stable(count_value)) else $error("count moved");
  AST_WRITE_WINS:
    assert property (wr && paddr == 8'h08 |=> count_value[7:0] == $past(pwdata[7:0]))
      else $error("cpu write lost");
  AST_BOTTOM:
    assert property ($past(presetn) |-> bottom_hit == ($past(count_value) == 16'h0))
      else $error("bottom indication");
endmodule // tcs_timer_checker

bind tcs_timer tcs_timer_checker u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .psc_reset_ext(psc_reset_ext),
  .external_count_pin(external_count_pin), .timer_tick(timer_tick),
  .count_value(count_value), .bottom_hit(bottom_hit)
);

//--- bench/tcs_pin_src.sv
// off-chip clock source driving the count pin
`timescale 1ns/1ps
module tcs_pin_src #(
  parameter int HALF = 3
) (
  input  wire logic pclk,
  input  wire logic run,
  output logic      pin
);
  int cnt = 0;

  initial pin = 1'b0;
  // halts without toggling so the select can be changed on a steady pin
  always @(posedge pclk)
    if (run) begin
      if (cnt == HALF - 1) begin
        cnt <= 0;
        pin <= ~pin;
      end else cnt <= cnt + 1;
    end
endmodule // tcs_pin_src

//--- bench/tb_timer_clock_select_counter.sv
// testbench for tick selection, prescaler, pin counting and counter access
`timescale 1ns/1ps
`include "tcs_consts.vh"
module tb_timer_clock_select_counter;
  logic        pclk, presetn, psel, penable, pwrite, psc_reset_ext, run, err, top_seen;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, pin, timer_tick, top_hit, bottom_hit, overflow_flag;
  logic [15:0] count_value;
  int          miscompares, total_checks, cycles, n, k;
  int          divs [4] = '{1024, 256, 64, 8};

  tcs_timer DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_count_pin(pin), .psc_reset_ext(psc_reset_ext),
    .timer_tick(timer_tick), .count_value(count_value), .top_hit(top_hit),
    .bottom_hit(bottom_hit), .overflow_flag(overflow_flag));
  tcs_pin_src #(.HALF(3)) u_src (.pclk(pclk), .run(run), .pin(pin));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic complete_run;
    if (miscompares == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 12000) begin
      miscompares = miscompares + 1;
      complete_run();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_tick;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (timer_tick !== 1'b1);
  endtask

  // ---------------------------------------------------------------------------
  // stimulus
  // ---------------------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, psc_reset_ext, run} = 6'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, `TCS_ADDR_CNT_HI, 32'h01);
    apb(1'b1, `TCS_ADDR_CNT_LO, 32'hff);
    @(negedge pclk);
    chk("count", count_value, 32'h01ff);
    apb(1'b0, `TCS_ADDR_CNT_LO, 32'h0);
    chk("count_lo", rd, 32'hff);
    apb(1'b0, `TCS_ADDR_CNT_HI, 32'h0);
    chk("count_hi", rd, 32'h01);
    apb(1'b1, `TCS_ADDR_CMP_A_HI, 32'hab);
    apb(1'b1, `TCS_ADDR_CNT_LO, 32'h22);
    @(negedge pclk);
    chk("shared_hold", count_value, 32'hab22);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", {rd[30:0], err}, 32'h1);
    // longest tap first so the divide-by-8 run ends next to the reset test
    foreach (divs[i]) begin
      apb(1'b1, `TCS_ADDR_CTRL_B, 32'(5 - i));
      wait_tick();
      chk("first_tick", k <= divs[i] + 1, 1);
      wait_tick();
      chk("tap_period", k, divs[i]);
    end
    psc_reset_ext <= 1'b1;
    repeat (5) @(posedge pclk);
    psc_reset_ext <= 1'b0;
    wait_tick();
    chk("restart", k, 8);
    apb(1'b1, `TCS_ADDR_PSC_CTRL, 32'h1);
    wait_tick();
    chk("sw_restart", k, 8);
    psc_reset_ext <= 1'b1;
    apb(1'b1, `TCS_ADDR_CTRL_B, 32'h0);
    psc_reset_ext <= 1'b0;
    for (int s = 7; s >= 6; s--) begin
      apb(1'b1, `TCS_ADDR_CNT_HI, 32'h0);
      apb(1'b1, `TCS_ADDR_CNT_LO, 32'h0);
      apb(1'b1, `TCS_ADDR_CTRL_B, 32'(s));
      run <= 1'b1;
      repeat (48) @(posedge pclk);
      run <= 1'b0;
      repeat (6) @(posedge pclk);
      apb(1'b1, `TCS_ADDR_CTRL_B, 32'h0);
      chk("pin_ticks", count_value, 32'h8);
    end
    apb(1'b1, `TCS_ADDR_CNT_HI, 32'hff);
    apb(1'b1, `TCS_ADDR_CNT_LO, 32'hfd);
    apb(1'b1, `TCS_ADDR_CTRL_B, 32'h1);
    repeat (8) @(posedge pclk);
    apb(1'b1, `TCS_ADDR_CTRL_B, 32'h0);
    apb(1'b0, `TCS_ADDR_FLAGS, 32'h0);
    chk("overflow", {rd[0], overflow_flag}, 32'h3);
    apb(1'b1, `TCS_ADDR_FLAGS, 32'h1);
    apb(1'b0, `TCS_ADDR_FLAGS, 32'h0);
    chk("overflow_clr", rd[0], 32'h0);
    apb(1'b1, `TCS_ADDR_CMP_A_HI, 32'h0);
    apb(1'b1, `TCS_ADDR_CMP_A_LO, 32'h5);
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, `TCS_ADDR_CTRL_A, m ? 32'h3 : 32'h0);
      apb(1'b1, `TCS_ADDR_CNT_LO, 32'h0);
      apb(1'b1, `TCS_ADDR_CTRL_B, m ? 32'h11 : 32'h09);
      top_seen = 1'b0;
      repeat (40) begin
        @(negedge pclk);
        chk("within_top", count_value <= 16'h5, 32'h1);
        top_seen = top_seen | top_hit;
      end
      apb(1'b1, `TCS_ADDR_CTRL_B, 32'h0);
      chk("top_seen", top_seen, 32'h1);
    end
    complete_run();
  end
endmodule // tb_timer_clock_select_counter
